// [bench/drab_bridge_chk.sv]
// port checker for the register access bridge
`timescale 1ns/100ps
module drab_bridge_chk (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        objDone,
  input wire logic [31:0] objAbort,
  input wire logic        drvReq,
  input wire logic        drvAck,
  input wire logic [7:0]  faultEnum,
  input wire logic        cardFault,
  input wire logic [7:0]  errRegister,
  input wire logic        emcyValid,
  input wire logic [63:0] emcyFrame,
  input wire logic [15:0] errField1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_emcy_once: assert property (emcyValid |=> !emcyValid)
    else $error("emergency pulse too long");
  a_emcy_fill: assert property (emcyValid |-> emcyFrame[63:24] == 40'h0)
    else $error("emergency filler not zero");
  a_emcy_reg: assert property (emcyValid |-> emcyFrame[23:16] == errRegister)
    else $error("emergency error register wrong");
  a_field_code: assert property (emcyValid |=> errField1 == $past(emcyFrame[15:0]))
    else $error("error field not updated");
  a_card_code: assert property ($rose(cardFault) && faultEnum == 8'h00 |-> ##[1:8] (emcyValid && emcyFrame[15:0] == 16'h5481))
    else $error("card fault code missing");
  a_uv_code: assert property ($changed(faultEnum) && faultEnum == 8'h03 |-> ##[1:8] (emcyValid && emcyFrame[15:0] == 16'h5200))
    else $error("undervoltage code missing");
  a_term_code: assert property ($changed(faultEnum) && faultEnum == 8'h42 |-> ##[1:8] (emcyValid && emcyFrame[15:0] == 16'hFF0D))
    else $error("terminal fault code missing");
  a_req_hold: assert property (drvReq && !drvAck |=> drvReq)
    else $error("drive request dropped early");
  a_abort_code: assert property (objDone |-> objAbort == 32'h0 || objAbort == 32'h0602_0010)
    else $error("unexpected abort code");
  cover property (objDone && objAbort != 32'h0);
  cover property (emcyValid);
  cover property (drvReq && drvAck);
endmodule // drab_bridge_chk

// [bench/drab_drive_model.sv]
// drive register space answering the bridge after a short delay
`timescale 1ns/100ps
module drab_drive_model (
  input  wire logic        core_clk,
  input  wire logic        drvReq,
  input  wire logic        drvWrite,
  input  wire logic [15:0] drvAddr,
  input  wire logic [15:0] drvWrData,
  output logic             drvAck,
  output logic             drvErr,
  output logic [15:0]      drvRdData,
  output logic [15:0]      lastAddr,
  output logic [15:0]      lastData,
  output int               wrCount
);
  logic [15:0] value = 16'h0000;
  int          delayCnt = 0;
  initial begin
    drvAck = 1'b0; drvErr = 1'b0; drvRdData = 16'hFFFF;
    lastAddr = 16'h0000; lastData = 16'h0000; wrCount = 0;
  end
  always @(posedge core_clk) begin
    drvAck <= 1'b0;
    // data is only valid with ack, so it toggles otherwise
    drvRdData <= ~drvRdData;
    if (drvReq && !drvAck) begin
      delayCnt <= delayCnt + 1;
      if (delayCnt == 3) begin
        delayCnt <= 0;
        drvAck <= 1'b1;
        drvRdData <= value;
        if (drvWrite) begin
          value <= drvWrData;
          lastAddr <= drvAddr;
          lastData <= drvWrData;
          wrCount <= wrCount + 1;
        end
      end
    end
  end
endmodule // drab_drive_model

// [bench/tb.sv]
// self-checking bench for the register access bridge
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb;
  logic        core_clk = 0, reset_n = 0, objWrStb = 0, objRdStb = 0;
  logic [15:0] objIndex = 16'h0000;
  logic [31:0] objWrData = 32'h0000_0000, rd, ab;
  logic [7:0]  faultEnum = 8'h00, errRegister = 8'h81;
  logic        cardFault = 0, objDone, drvReq, drvWrite, drvAck, drvErr;
  logic        emcyValid;
  logic [31:0] objRdData, objAbort;
  logic [15:0] drvAddr, drvWrData, drvRdData, errField1, lastAddr, lastData;
  logic [63:0] emcyFrame, frame;
  int          fails = 0, checks = 0, n, pulses, wrCount, c;
  localparam logic [31:0] SAVE = 32'h7361_7665;
  always #5 core_clk = ~core_clk;
  drab_bridge dut (.core_clk(core_clk), .reset_n(reset_n),
    .objWrStb(objWrStb), .objRdStb(objRdStb), .objIndex(objIndex),
    .objSub(8'h00), .objWrData(objWrData), .objDone(objDone),
    .objRdData(objRdData), .objAbort(objAbort), .drvReq(drvReq),
    .drvWrite(drvWrite), .drvAddr(drvAddr), .drvWrData(drvWrData),
    .drvAck(drvAck), .drvErr(drvErr), .drvRdData(drvRdData),
    .faultEnum(faultEnum), .cardFault(cardFault),
    .errRegister(errRegister), .emcyValid(emcyValid),
    .emcyFrame(emcyFrame), .errField1(errField1));
  drab_drive_model drv (.core_clk(core_clk), .drvReq(drvReq),
    .drvWrite(drvWrite), .drvAddr(drvAddr), .drvWrData(drvWrData),
    .drvAck(drvAck), .drvErr(drvErr), .drvRdData(drvRdData),
    .lastAddr(lastAddr), .lastData(lastData), .wrCount(wrCount));
  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one object access; the long wait covers the drive's settle time
  task acc(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge core_clk) #1;
    objWrStb = w; objRdStb = !w; objIndex = idx; objWrData = d;
    @(posedge core_clk) #1;
    objWrStb = 0; objRdStb = 0; n = 0;
    while (objDone !== 1'b1) begin
      if (n == 20) begin fails++; wrap_up; end
      n++; @(posedge core_clk) #1;
    end
    rd = objRdData; ab = objAbort;
    repeat (1020) @(posedge core_clk);
  endtask
  task t_rw;
    acc(0, 16'h2140, 0);
    `CHK("no address abort", 32'h0602_0010, ab)
    acc(1, 16'h2050, {16'h0200, 16'h1234});
    `CHK("drive address", 16'h0200, lastAddr)
    acc(0, 16'h2150, 0);
    `CHK("write response", 32'h0000_0200, rd)
    acc(1, 16'h2040, 32'h0000_0200);
    acc(0, 16'h2140, 0);
    `CHK("read response", 32'h0000_1234, rd)
    `CHK("read abort", 32'h0000_0000, ab)
    $display("test read write done");
  endtask
  task t_enter;
    c = wrCount;
    acc(1, 16'h2060, 32'h7361_7666);
    `CHK("bad enter word", c, wrCount)
    acc(1, 16'h2060, SAVE);
    `CHK("ram enter", 16'h0910, lastAddr)
    acc(0, 16'h2160, 0);
    `CHK("enter response", 32'h0000_0001, rd)
    acc(1, 16'h2070, SAVE);
    `CHK("rom enter", 16'h0900, lastAddr)
    acc(1, 16'h2040, 32'h0000_04C3);
    acc(0, 16'h2140, 0);
    `CHK("select read abort", 32'h0000_0000, ab)
    acc(1, 16'h2050, {16'h04C3, 16'h0000});
    `CHK("select cleared", 16'h04C3, lastAddr)
    acc(1, 16'h1011, 32'h0000_08AC);
    `CHK("init register", 16'h0103, lastAddr)
    `CHK("init code", 16'h08AC, lastData)
    acc(1, 16'h2070, SAVE);
    `CHK("final enter", 16'h0900, lastAddr)
    $display("test enter done");
  endtask
  task t_fault(input logic [7:0] e, input logic card, input logic [15:0] code);
    @(posedge core_clk) #1;
    faultEnum = e; cardFault = card; pulses = 0; frame = 64'h0;
    repeat (30) begin
      @(posedge core_clk) #1;
      if (emcyValid === 1'b1) begin pulses++; frame = emcyFrame; end
    end
    `CHK("emergency code", code, frame[15:0])
    `CHK("frame tail", 48'h0000_0000_0081, frame[63:16])
    `CHK("error field", code, errField1)
    `CHK("pulse count", 1, pulses)
    faultEnum = 8'h00; cardFault = 0;
    repeat (30) @(posedge core_clk);
    $display("test fault %h done", e);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1;
    t_rw;
    t_enter;
    t_fault(8'h03, 0, 16'h5200);
    t_fault(8'h27, 0, 16'h5481);
    t_fault(8'h42, 0, 16'hFF0D);
    t_fault(8'h00, 1, 16'h5481);
    wrap_up;
  end
endmodule // tb
bind drab_bridge drab_bridge_chk chk (.core_clk(core_clk), .reset_n(reset_n),
  .objDone(objDone), .objAbort(objAbort), .drvReq(drvReq), .drvAck(drvAck),
  .faultEnum(faultEnum), .cardFault(cardFault), .errRegister(errRegister),
  .emcyValid(emcyValid), .emcyFrame(emcyFrame), .errField1(errField1));

// [logic/drab_bridge.v]
// object-dictionary bridge between a fieldbus master and drive registers
`timescale 1ns/100ps
`include "drab_consts.vh"
module drab_bridge (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        objWrStb,
  input  wire        objRdStb,
  input  wire [15:0] objIndex,
  input  wire [7:0]  objSub,
  input  wire [31:0] objWrData,
  output reg         objDone,
  output reg  [31:0] objRdData,
  output reg  [31:0] objAbort,
  output reg         drvReq,
  output reg         drvWrite,
  output reg  [15:0] drvAddr,
  output reg  [15:0] drvWrData,
  input  wire        drvAck,
  input  wire        drvErr,
  input  wire [15:0] drvRdData,
  input  wire [7:0]  faultEnum,
  input  wire        cardFault,
  input  wire [7:0]  errRegister,
  output reg         emcyValid,
  output reg  [63:0] emcyFrame,
  output reg  [15:0] errField1
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_BUSY = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;

  localparam [1:0] OP_READ  = 2'd0;
  localparam [1:0] OP_WRITE = 2'd1;
  localparam [1:0] OP_RAM   = 2'd2;
  localparam [1:0] OP_ROM   = 2'd3;

  localparam [15:0] WAIT_CNT = `DRAB_WAIT_CYCLES;

  function [15:0] emcyCode;
    input [7:0] code;
    begin
      case (code)
        `DRAB_ENUM_UV2: emcyCode = `DRAB_EMCY_UV2; // see RULE_20
        `DRAB_ENUM_EF0: emcyCode = `DRAB_EMCY_EF0; // see RULE_21
        `DRAB_ENUM_EF1: emcyCode = `DRAB_EMCY_EF1; // see RULE_22
        default:        emcyCode = `DRAB_EMCY_GENERIC;
      endcase
    end
  endfunction

  // fault inputs come from the drive side, so synchronise them first
  reg [7:0]  faultMeta_reg;
  reg [7:0]  faultSync_reg;
  reg        cardMeta_reg;
  reg        cardSync_reg;
  reg [7:0]  faultLast_reg;
  reg        cardLast_reg;

  reg [1:0]  state_reg;
  reg [1:0]  op_reg;
  reg [15:0] waitCnt_reg;
  reg [15:0] readAddr_reg;
  reg        readValid_reg;
  reg [15:0] readRsp_reg;
  reg        writeValid_reg;
  reg [15:0] writeRsp_reg;
  reg [15:0] enterRsp_reg;

  wire isSave  = (objWrData == `DRAB_SAVE_WORD);
  wire accept  = (state_reg == ST_IDLE);

  always @(posedge core_clk) begin
    if (!reset_n) begin
      faultMeta_reg <= 8'h00;
      faultSync_reg <= 8'h00;
      cardMeta_reg  <= 1'b0;
      cardSync_reg  <= 1'b0;
      faultLast_reg <= 8'h00;
      cardLast_reg  <= 1'b0;
      emcyValid     <= 1'b0;
      emcyFrame     <= 64'h0000_0000_0000_0000;
      errField1     <= 16'h0000;
    end else begin
      faultMeta_reg <= faultEnum;
      faultSync_reg <= faultMeta_reg;
      cardMeta_reg  <= cardFault;
      cardSync_reg  <= cardMeta_reg;
      faultLast_reg <= faultSync_reg;
      cardLast_reg  <= cardSync_reg;
      emcyValid     <= 1'b0;
      // a new event is a change to a nonzero enum, or a card fault rising
      if (faultSync_reg != faultLast_reg &&
          faultSync_reg != `DRAB_ENUM_NONE) begin // see RULE_18
        emcyValid <= 1'b1;
        errField1 <= emcyCode(faultSync_reg); // see RULE_17
        emcyFrame <= {40'h00_0000_0000, errRegister,
                      emcyCode(faultSync_reg)}; // see RULE_19
      end else if (cardSync_reg && !cardLast_reg) begin // see RULE_18
        emcyValid <= 1'b1;
        errField1 <= `DRAB_EMCY_EF0; // see RULE_21
        emcyFrame <= {40'h00_0000_0000, errRegister,
                      `DRAB_EMCY_EF0}; // see RULE_19
      end
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg      <= ST_IDLE;
      op_reg         <= OP_READ;
      waitCnt_reg    <= 16'h0000;
      readAddr_reg   <= 16'h0000;
      readValid_reg  <= 1'b0;
      readRsp_reg    <= 16'h0000;
      writeValid_reg <= 1'b0;
      writeRsp_reg   <= 16'h0000;
      enterRsp_reg   <= 16'h0000;
      objDone        <= 1'b0;
      objRdData      <= 32'h0000_0000;
      objAbort       <= 32'h0000_0000;
      drvReq         <= 1'b0;
      drvWrite       <= 1'b0;
      drvAddr        <= 16'h0000;
      drvWrData      <= 16'h0000;
    end else begin
      objDone <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (objWrStb) begin
            objDone  <= 1'b1;
            objAbort <= `DRAB_ABORT_NONE;
            case (objIndex)
              `DRAB_OBJ_READ_REQ: begin // see RULE_03
                readAddr_reg  <= objWrData[15:0]; // see RULE_01
                readValid_reg <= 1'b1;
                op_reg        <= OP_READ;
                drvReq        <= 1'b1;
                drvWrite      <= 1'b0;
                drvAddr       <= objWrData[15:0];
                state_reg     <= ST_BUSY;
              end
              `DRAB_OBJ_WRITE_REQ: begin // see RULE_12
                // upper half is the address, lower half the value
                op_reg    <= OP_WRITE;
                drvReq    <= 1'b1;
                drvWrite  <= 1'b1;
                drvAddr   <= objWrData[31:16]; // see RULE_04
                drvWrData <= objWrData[15:0];
                state_reg <= ST_BUSY;
              end
              `DRAB_OBJ_RESTORE: begin
                // the drive only acts on it after select 0 plus an Enter
                op_reg    <= OP_WRITE;
                drvReq    <= 1'b1;
                drvWrite  <= 1'b1;
                drvAddr   <= `DRAB_REG_INIT_MODE; // see RULE_13
                drvWrData <= objWrData[15:0];
                state_reg <= ST_BUSY;
              end
              `DRAB_OBJ_RAM_ENTER,
              `DRAB_OBJ_ROM_ENTER: begin
                if (isSave) begin // see RULE_08
                  op_reg    <= (objIndex == `DRAB_OBJ_RAM_ENTER) ?
                               OP_RAM : OP_ROM;
                  drvReq    <= 1'b1;
                  drvWrite  <= 1'b1;
                  drvAddr   <= (objIndex == `DRAB_OBJ_RAM_ENTER) ?
                               `DRAB_REG_ENTER_RAM :
                               `DRAB_REG_ENTER_ROM; // see RULE_06 RULE_07
                  drvWrData <= 16'h0000;
                  state_reg <= ST_BUSY;
                end
              end
              default: begin
              end
            endcase
          end else if (objRdStb) begin
            objDone   <= 1'b1;
            objAbort  <= `DRAB_ABORT_NONE;
            objRdData <= 32'h0000_0000;
            case (objIndex)
              `DRAB_OBJ_READ_RSP: begin
                if (readValid_reg)
                  objRdData <= {16'h0000, readRsp_reg}; // see RULE_02
                else
                  objAbort <= `DRAB_ABORT_NO_ADDR; // see RULE_23
              end
              `DRAB_OBJ_WRITE_RSP: begin
                if (writeValid_reg)
                  objRdData <= {16'h0000, writeRsp_reg}; // see RULE_05
                else
                  objAbort <= `DRAB_ABORT_NO_ADDR; // see RULE_23
              end
              `DRAB_OBJ_ENTER_RSP:
                objRdData <= {16'h0000, enterRsp_reg}; // see RULE_09
              `DRAB_OBJ_ERR_FIELD:
                objRdData <= {16'h0000, errField1}; // see RULE_17
              `DRAB_OBJ_READ_REQ:
                objRdData <= {16'h0000, readAddr_reg};
              default: begin
              end
            endcase
          end
        end
        ST_BUSY: begin
          if (drvAck) begin
            drvReq <= 1'b0;
            case (op_reg)
              OP_READ: begin
                readRsp_reg   <= drvErr ? 16'hFFFF : drvRdData;
                readValid_reg <= !drvErr;
              end
              OP_WRITE: begin
                writeRsp_reg   <= drvErr ? 16'hFFFF : drvAddr;
                writeValid_reg <= !drvErr;
              end
              OP_RAM:
                enterRsp_reg <= drvErr ? 16'hFFFF : 16'h0001;
              default: begin
              end
            endcase
            // settle time so the drive can activate changes
            waitCnt_reg <= WAIT_CNT;
            state_reg   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (waitCnt_reg <= 16'h0001)
            state_reg <= ST_IDLE;
          else
            waitCnt_reg <= waitCnt_reg - 16'h0001;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // drab_bridge

// [logic/drab_consts.vh]
// constants of the drive register access bridge
// Contract
// RULE_01: master writes drive register address to read-request subindex 0 first.
// RULE_02: bridge returns read register value in read-response subindex 1.
// RULE_03: read-request and read-response objects are mappable to cyclic process data.
// RULE_04: master writes value and address together into write-request subindex 1.
// RULE_05: bridge places a write response in write-response subindex 1.
// RULE_06: with enter-required select 0, writes take effect after RAM Enter.
// RULE_07: ROM Enter instead of RAM Enter stores changes non-volatile.
// RULE_08: an Enter is triggered only by writing the ASCII bytes "save".
// RULE_09: bridge reports RAM Enter outcome in the enter-response object.
// RULE_10: one Enter after the last write activates all pending changes.
// RULE_11: master waits between writes and after an Enter command.
// RULE_12: write-request, enter objects and responses are mappable to process data.
// RULE_13: initialization register acts only with select zero and a following Enter.
// RULE_14: master reads enter-required select and clears it before initializing.
// RULE_15: two-wire initialization uses code 08AC hex, 2220 decimal.
// RULE_16: master finishes initialization with an Unlimited Enter via ROM-enter.
// RULE_17: bridge records emergency code in predefined error field subindex 01.
// RULE_18: one emergency message per drive or card fault event; a card fault rising in the same cycle as a change to a nonzero enum gets none.
// RULE_19: emergency carries code, error register, then zero filler bytes.
// RULE_20: fault enumeration 0x03 maps to emergency code 5200.
// RULE_21: fault enumeration 0x27 maps to emergency code 5481.
// RULE_22: fault enumeration 0x42 maps to emergency code FF0D.
// RULE_23: response read without valid prior address aborts with 0602 0010.
`ifndef DRAB_CONSTS_VH
`define DRAB_CONSTS_VH
`define DRAB_OBJ_READ_REQ     16'h2040
`define DRAB_OBJ_WRITE_REQ    16'h2050
`define DRAB_OBJ_RAM_ENTER    16'h2060
`define DRAB_OBJ_ROM_ENTER    16'h2070
`define DRAB_OBJ_READ_RSP     16'h2140
`define DRAB_OBJ_WRITE_RSP    16'h2150
`define DRAB_OBJ_ENTER_RSP    16'h2160
`define DRAB_OBJ_RESTORE      16'h1011
`define DRAB_OBJ_ERR_FIELD    16'h1003
`define DRAB_REG_INIT_MODE    16'h0103
`define DRAB_REG_ENTER_SEL    16'h04C3
`define DRAB_REG_ENTER_RAM    16'h0910
`define DRAB_REG_ENTER_ROM    16'h0900
`define DRAB_SAVE_WORD        32'h7361_7665
`define DRAB_ABORT_NO_ADDR    32'h0602_0010
`define DRAB_ABORT_NONE       32'h0000_0000
`define DRAB_ENUM_UV2         8'h03
`define DRAB_ENUM_EF0         8'h27
`define DRAB_ENUM_EF1         8'h42
`define DRAB_ENUM_NONE        8'h00
`define DRAB_EMCY_UV2         16'h5200
`define DRAB_EMCY_EF0         16'h5481
`define DRAB_EMCY_EF1         16'hFF0D
`define DRAB_EMCY_GENERIC     16'h1000
`define DRAB_WAIT_US          16'h000A
`define DRAB_CLK_MHZ          16'h0064
`define DRAB_WAIT_CYCLES      (`DRAB_WAIT_US * `DRAB_CLK_MHZ)
`endif
